// ===== design/adc_control_byte_parallel_port.sv
// control byte decode, conversion clocking and byte-wide host port
//
// Contract
// - power bits 00 give full power-down, 01 standby; clock mode untouched.
// - power bits 10 run on internal clock, 11 on external clock.
// - power-down bytes keep the clock mode of the last run byte.
// - after reset the external clock mode is in force.
// - bit 5 clear gives timed acquisition, set gives host-timed acquisition.
// - bit 4 set selects single-ended against the shared return.
// - bit 3 clear selects bipolar range, set selects unipolar range.
// - single-ended address n makes input n positive, shared return negative.
// - pseudo-differential pairs by upper address bits; address LSB picks positive.
// - internal clock gives a conversion of about 3.6 us.
// - chip select high ignores clock and strobes, bus released.
// - control and results share one three-state byte bus.
// - control byte captured from the bus on a chip-selected write.
// - unipolar results straight binary, bipolar results two's complement.
// - byte select low drives result bits 7..0 on a read.
// - byte select high drives bits 11..8, upper lines zero or sign.
// - each conversion takes 13 conversion clocks.
// - done goes low on a result, high on a read or a write.
// - timed acquisition lasts three clocks then conversion starts itself.
// - a write during conversion aborts it and restarts acquisition.
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

module adc_control_byte_parallel_port (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chipSelN,
    input wire logic writeN,
    input wire logic readN,
    input wire logic high_byte_select,
    input wire logic convClkPin,
    input wire logic [7:0] dataIn,
    output logic [7:0] dataOut,
    output logic dataOeN,
    output logic convDoneN,
    output logic compHigh_unused_n,
    input wire logic compHigh,
    output logic [11:0] dacCode,
    output logic trackHold,
    output logic convBusy,
    output logic [2:0] posChannel,
    output logic [2:0] negChannel,
    output logic negIsSharedReturn,
    output logic bipolarRange,
    output logic internalClkMode,
    output logic fullPowerDown,
    output logic standbyMode
);

    // ----------------------------------------
    // pin synchronisers and agreement filter
    // ----------------------------------------
    logic [12:0] pinRaw;
    logic [12:0] pinS1_ff;
    logic [12:0] pinS2_ff;
    logic [12:0] pinS3_ff;
    logic [12:0] pinFilt_ff;

    assign pinRaw = {convClkPin, high_byte_select, readN, writeN, chipSelN, dataIn};

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pinS1_ff <= `PIN_IDLE;
            pinS2_ff <= `PIN_IDLE;
            pinS3_ff <= `PIN_IDLE;
        end else begin
            pinS1_ff <= pinRaw;
            pinS2_ff <= pinS1_ff;
            pinS3_ff <= pinS2_ff;
        end
    end

    localparam logic [12:0] PIN_IDLE_BITS = `PIN_IDLE;

    genvar gi;
    generate
        for (gi = 0; gi < `PIN_COUNT; gi = gi + 1) begin : g_filt
            always_ff @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    pinFilt_ff[gi] <= PIN_IDLE_BITS[gi];
                end else if (pinS2_ff[gi] == pinS3_ff[gi]) begin
                    pinFilt_ff[gi] <= pinS3_ff[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // strobe edges
    // ----------------------------------------
    logic csActive;
    logic wrLowQ_ff;
    logic rdLowQ_ff;
    logic clkHighQ_ff;
    logic wrLow;
    logic rdLow;
    logic writeEvent;
    logic readStart;
    logic extTick;

    // chip select high masks every strobe and the clock
    assign csActive = ~pinFilt_ff[`PIN_CS_N];
    assign wrLow = csActive & ~pinFilt_ff[`PIN_WR_N];
    assign rdLow = csActive & ~pinFilt_ff[`PIN_RD_N];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wrLowQ_ff <= 1'b0;
            rdLowQ_ff <= 1'b0;
            // same idle level as the filtered clock, so reset makes no edge
            clkHighQ_ff <= 1'b1;
        end else begin
            wrLowQ_ff <= wrLow;
            rdLowQ_ff <= rdLow;
            clkHighQ_ff <= pinFilt_ff[`PIN_CONV_CLK];
        end
    end

    // a write takes effect on the rising edge of the write strobe
    assign writeEvent = wrLowQ_ff & ~wrLow & csActive;
    assign readStart = rdLow & ~rdLowQ_ff;
    assign extTick = csActive & pinFilt_ff[`PIN_CONV_CLK] & ~clkHighQ_ff;

    // ----------------------------------------
    // control byte register
    // ----------------------------------------
    logic [7:0] ctrl_ff;
    logic clkExt_ff;
    logic [7:0] wrByte;

    assign wrByte = pinFilt_ff[`PIN_DATA_HI:`PIN_DATA_LO];

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_ff <= `CTL_RESET;
        end else if (writeEvent) begin
            ctrl_ff <= wrByte;
        end
    end

    // clock mode moves only on a run byte
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clkExt_ff <= `CLK_EXT_RESET;
        end else if (writeEvent && wrByte[`CTL_POWER_HI_BIT]) begin
            clkExt_ff <= wrByte[`CTL_POWER_LO_BIT];
        end
    end

    // ----------------------------------------
    // field decode
    // ----------------------------------------
    adc_ctrl_pkg::power_sel_type powerSel;
    logic acqHostTimed;
    logic singleEnded;
    logic [2:0] chanAddr;

    assign powerSel = adc_ctrl_pkg::power_sel_type'(
        {ctrl_ff[`CTL_POWER_HI_BIT], ctrl_ff[`CTL_POWER_LO_BIT]});
    assign acqHostTimed = ctrl_ff[`CTL_ACQ_STYLE_BIT];
    assign singleEnded = ctrl_ff[`CTL_SINGLE_END_BIT];
    assign bipolarRange = ~ctrl_ff[`CTL_POLARITY_BIT];
    assign chanAddr = ctrl_ff[`CTL_ADDR_HI_BIT:`CTL_ADDR_LO_BIT];
    assign internalClkMode = ~clkExt_ff;

    always_comb begin
        fullPowerDown = 1'b0;
        standbyMode = 1'b0;
        case (powerSel)
            adc_ctrl_pkg::PWR_FULL_DOWN: fullPowerDown = 1'b1;
            adc_ctrl_pkg::PWR_STANDBY: standbyMode = 1'b1;
            default: begin
                fullPowerDown = 1'b0;
                standbyMode = 1'b0;
            end
        endcase
    end

    // ----------------------------------------
    // input multiplexer selection
    // ----------------------------------------
    // returns {negIsShared, negChannel, posChannel}
    function automatic logic [6:0] muxSelect(input logic single, input logic [2:0] addr);
        logic [2:0] partner;
        partner = {addr[2:1], ~addr[0]};
        if (single) begin
            muxSelect = {1'b1, 3'h0, addr};
        end else begin
            muxSelect = {1'b0, partner, addr};
        end
    endfunction : muxSelect

    logic [6:0] muxSel;

    assign muxSel = muxSelect(singleEnded, chanAddr);
    assign posChannel = muxSel[2:0];
    assign negChannel = muxSel[5:3];
    assign negIsSharedReturn = muxSel[6];

    // ----------------------------------------
    // conversion clock
    // ----------------------------------------
    localparam logic [3:0] INT_TICK_LAST = 4'(`INT_TICK_CYC - 1);
    logic [3:0] intDiv_ff;
    logic intTick;
    logic convTick;

    // internal oscillator stand-in: 13 ticks span the conversion time
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            intDiv_ff <= 4'h0;
        end else if (writeEvent || intDiv_ff == INT_TICK_LAST) begin
            intDiv_ff <= 4'h0;
        end else begin
            intDiv_ff <= intDiv_ff + 4'h1;
        end
    end

    assign intTick = (intDiv_ff == INT_TICK_LAST);
    // external clock rate and duty are the host's concern
    assign convTick = clkExt_ff ? extTick : intTick;

    // ----------------------------------------
    // acquisition and conversion start
    // ----------------------------------------
    logic acqStart;
    logic convStart;
    logic acqTimed;
    logic rawDone;
    logic [11:0] rawResult;

    // second write with style cleared ends a host-timed acquisition
    assign convStart = writeEvent & trackHold & acqHostTimed
        & ~wrByte[`CTL_ACQ_STYLE_BIT];
    assign acqStart = writeEvent & ~convStart;
    assign acqTimed = ~acqHostTimed;

    sar_conversion_engine u_engine (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .convTick(convTick),
        .acqStart(acqStart),
        .acqTimed(acqTimed),
        .convStart(convStart),
        .compHigh(compHigh),
        .trackHold(trackHold),
        .convBusy(convBusy),
        .dacCode(dacCode),
        .rawResult(rawResult),
        .convDone(rawDone)
    );

    assign compHigh_unused_n = 1'b1;

    // ----------------------------------------
    // result word
    // ----------------------------------------
    logic [11:0] result_ff;
    logic resultBipolar_ff;

    // sar code is offset binary; bipolar flips the msb into two's complement
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            result_ff <= 12'h000;
            resultBipolar_ff <= 1'b0;
        end else if (rawDone) begin
            result_ff <= {rawResult[11] ^ bipolarRange, rawResult[10:0]};
            resultBipolar_ff <= bipolarRange;
        end
    end

    // ----------------------------------------
    // conversion done flag
    // ----------------------------------------
    logic done_ff;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            done_ff <= 1'b0;
        end else if (rawDone) begin
            done_ff <= 1'b1;
        end else if (readStart || writeEvent) begin
            done_ff <= 1'b0;
        end
    end

    assign convDoneN = ~done_ff;

    // ----------------------------------------
    // data bus output
    // ----------------------------------------
    logic [7:0] outByte_ff;
    logic [3:0] upperFill;

    assign upperFill = resultBipolar_ff ? {4{result_ff[11]}} : 4'h0;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            outByte_ff <= 8'h00;
        end else if (pinFilt_ff[`PIN_HB_SEL]) begin
            outByte_ff <= {upperFill, result_ff[11:8]};
        end else begin
            outByte_ff <= result_ff[7:0];
        end
    end

    assign dataOut = outByte_ff;
    // enable is low only for a chip-selected read
    assign dataOeN = ~(rdLow & rdLowQ_ff);

endmodule : adc_control_byte_parallel_port

// ===== design/sar_conversion_engine.sv
// acquisition timing and successive-approximation sequencer
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"

module sar_conversion_engine (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic convTick,
    input wire logic acqStart,
    input wire logic acqTimed,
    input wire logic convStart,
    input wire logic compHigh,
    output logic trackHold,
    output logic convBusy,
    output logic [11:0] dacCode,
    output logic [11:0] rawResult,
    output logic convDone
);

    adc_ctrl_pkg::sar_state_type state_ff;
    logic [3:0] tickCnt_ff;
    logic [11:0] dac_ff;
    logic [11:0] raw_ff;
    logic done_ff;
    logic [3:0] trialIdx;

    assign trialIdx = 4'(`RESULT_MSB) - tickCnt_ff;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= adc_ctrl_pkg::SAR_IDLE;
            tickCnt_ff <= 4'h0;
            dac_ff <= 12'h000;
            raw_ff <= 12'h000;
            done_ff <= 1'b0;
        end else begin
            done_ff <= 1'b0;
            if (convStart) begin
                state_ff <= adc_ctrl_pkg::SAR_CONV;
                tickCnt_ff <= 4'h0;
                dac_ff <= `SAR_FIRST_TRIAL;
            end else if (acqStart) begin
                state_ff <= adc_ctrl_pkg::SAR_ACQ;
                tickCnt_ff <= 4'h0;
            end else if (convTick) begin
                case (state_ff)
                    adc_ctrl_pkg::SAR_ACQ: begin
                        if (acqTimed && tickCnt_ff == 4'(`ACQ_CLOCKS - 1)) begin
                            state_ff <= adc_ctrl_pkg::SAR_CONV;
                            tickCnt_ff <= 4'h0;
                            dac_ff <= `SAR_FIRST_TRIAL;
                        end else if (acqTimed) begin
                            tickCnt_ff <= tickCnt_ff + 4'h1;
                        end
                    end
                    adc_ctrl_pkg::SAR_CONV: begin
                        if (tickCnt_ff == 4'(`CONV_CLOCKS - 1)) begin
                            state_ff <= adc_ctrl_pkg::SAR_IDLE;
                            raw_ff <= dac_ff;
                            done_ff <= 1'b1;
                        end else begin
                            tickCnt_ff <= tickCnt_ff + 4'h1;
                            if (tickCnt_ff <= 4'(`RESULT_MSB)) begin
                                dac_ff[trialIdx] <= compHigh;
                                if (trialIdx != 4'h0) begin
                                    dac_ff[trialIdx - 4'h1] <= 1'b1;
                                end
                            end
                        end
                    end
                    default: begin
                        state_ff <= adc_ctrl_pkg::SAR_IDLE;
                    end
                endcase
            end
        end
    end

    assign trackHold = (state_ff == adc_ctrl_pkg::SAR_ACQ);
    assign convBusy = (state_ff == adc_ctrl_pkg::SAR_CONV);
    assign dacCode = dac_ff;
    assign rawResult = raw_ff;
    assign convDone = done_ff;

endmodule : sar_conversion_engine

// ===== include/adc_ctrl_defs.svh
// constants for the converter control and parallel port block
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// control byte field positions
`define CTL_POWER_HI_BIT 7
`define CTL_POWER_LO_BIT 6
`define CTL_ACQ_STYLE_BIT 5
`define CTL_SINGLE_END_BIT 4
`define CTL_POLARITY_BIT 3
`define CTL_ADDR_HI_BIT 2
`define CTL_ADDR_LO_BIT 0

// control byte reset value: normal operation, external clock
`define CTL_RESET 8'hC0
`define CLK_EXT_RESET 1'b1

// pin vector positions after synchronisation
`define PIN_DATA_LO 0
`define PIN_DATA_HI 7
`define PIN_CS_N 8
`define PIN_WR_N 9
`define PIN_RD_N 10
`define PIN_HB_SEL 11
`define PIN_CONV_CLK 12
`define PIN_COUNT 13
`define PIN_IDLE 13'h1F00

// timing
`define SYS_PERIOD_NS 20
`define CONV_TIME_NS 3600
`define CONV_CLOCKS 13
`define ACQ_CLOCKS 3
`define INT_TICK_CYC ((`CONV_TIME_NS / `CONV_CLOCKS) / `SYS_PERIOD_NS)

// result layout
`define RESULT_MSB 11
`define SAR_FIRST_TRIAL 12'h800

`endif

// ===== include/adc_ctrl_pkg.sv
// types for the converter control and parallel port block
package adc_ctrl_pkg;

    typedef enum logic [2:0] {
        SAR_IDLE = 3'b001,
        SAR_ACQ = 3'b010,
        SAR_CONV = 3'b100
    } sar_state_type;

    typedef enum logic [1:0] {
        PWR_FULL_DOWN = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_RUN_INT_CLK = 2'b10,
        PWR_RUN_EXT_CLK = 2'b11
    } power_sel_type;

endpackage : adc_ctrl_pkg

// ===== sim/adc_port_asserts.sv
// concurrent checks on the converter control and host port block
`timescale 1ns/1ps
module adc_port_asserts (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic chipSelN,
    input wire logic readN,
    input wire logic dataOeN,
    input wire logic convDoneN,
    input wire logic trackHold,
    input wire logic convBusy,
    input wire logic [2:0] posChannel,
    input wire logic [2:0] negChannel,
    input wire logic negIsSharedReturn,
    input wire logic bipolarRange,
    input wire logic internalClkMode,
    input wire logic fullPowerDown,
    input wire logic standbyMode
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------
    // conversion length counter
    // ----------------------------------------
    logic [8:0] busyCnt_ff;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            busyCnt_ff <= 9'h000;
        end else if (trackHold) begin
            busyCnt_ff <= 9'h000;
        end else if (convBusy) begin
            busyCnt_ff <= busyCnt_ff + 9'h001;
        end
    end

    sequence csIdle;
        chipSelN [*6];
    endsequence
    sequence rdIdle;
        readN [*6];
    endsequence

    chk_bus_cs_off: assert property (csIdle |-> dataOeN)
        else $error("bus driven while deselected");
    chk_bus_rd_off: assert property (rdIdle |-> dataOeN)
        else $error("bus driven without read");
    chk_read_clears: assert property ($fell(dataOeN) |-> convDoneN)
        else $error("done not cleared by read");
    chk_write_clears: assert property ($rose(trackHold) |-> convDoneN)
        else $error("done not cleared by write");
    chk_fields_held: assert property ($changed(bipolarRange) |-> convDoneN)
        else $error("range changed without write");
    chk_pwr_keeps_clk: assert property ((fullPowerDown || standbyMode)
        |-> $stable(internalClkMode))
        else $error("clock mode changed in power-down");
    chk_single_neg: assert property (negIsSharedReturn |-> negChannel == 3'h0)
        else $error("negative input wrong");
    chk_diff_pair: assert property (!negIsSharedReturn
        |-> (posChannel ^ negChannel) == 3'h1)
        else $error("pair wrong");
    chk_conv_length: assert property ($fell(convDoneN) && internalClkMode
        |-> busyCnt_ff inside {[150:185]})
        else $error("conversion length wrong");
    chk_done_after_busy: assert property ($fell(convDoneN)
        |-> $past(convBusy) || $past(convBusy, 2))
        else $error("done without conversion");
endmodule : adc_port_asserts

bind adc_control_byte_parallel_port adc_port_asserts chk (.clk_sys, .reset_n, .chipSelN,
    .readN, .dataOeN, .convDoneN, .trackHold, .convBusy, .posChannel, .negChannel,
    .negIsSharedReturn, .bipolarRange, .internalClkMode, .fullPowerDown, .standbyMode);

// ===== sim/analog_input_model.sv
// comparator front end holding one sampled input level
`timescale 1ns/1ps
module analog_input_model (
    input wire logic clk_sys,
    input wire logic trackHold,
    input wire logic [2:0] posChannel,
    input wire logic [11:0] dacCode,
    input wire logic [11:0] level [8],
    output logic compHigh
);
    logic [11:0] held_ff;
    // tracks the selected input, holds once tracking ends
    always_ff @(posedge clk_sys) begin
        if (trackHold) begin
            held_ff <= level[posChannel];
        end
    end
    assign compHigh = held_ff >= dacCode;
endmodule : analog_input_model

// ===== sim/testbench.sv
// self-checking bench for the converter control and host port block
`timescale 1ns/1ps
`define CHK(what, exp, got) \
    cmp_count++; \
    if ((got) !== (exp)) begin \
        $display("unexpected %s: expected %h seen %h", what, exp, got); \
        fail_count++; \
    end
module testbench;
    localparam logic [7:0] PWR_BYTE [6] = '{8'h80, 8'h00, 8'h40, 8'hC0, 8'h00, 8'h40};
    localparam logic [2:0] PWR_EXP [6] = '{3'h4, 3'h6, 3'h5, 3'h0, 3'h2, 3'h1};
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic chipSelN = 1'b1;
    logic writeN = 1'b1;
    logic readN = 1'b1;
    logic high_byte_select = 1'b0;
    logic convClkPin = 1'b0;
    logic [7:0] hostData = 8'h00;
    logic [7:0] dataIn;
    logic [7:0] dataOut;
    logic dataOeN, convDoneN, compHigh, trackHold, convBusy;
    logic negIsSharedReturn, bipolarRange, internalClkMode, fullPowerDown, standbyMode;
    logic [11:0] dacCode;
    logic [2:0] posChannel, negChannel;
    logic [11:0] level [8];
    logic [7:0] rdLo, rdHi;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n = 0;

    // resolved bus level: the host drives whenever the device does not
    assign dataIn = !dataOeN ? dataOut : hostData;

    adc_control_byte_parallel_port dut (.clk_sys, .reset_n, .chipSelN, .writeN, .readN,
        .high_byte_select, .convClkPin, .dataIn, .dataOut, .dataOeN, .convDoneN,
        .compHigh_unused_n(), .compHigh, .dacCode, .trackHold, .convBusy, .posChannel,
        .negChannel, .negIsSharedReturn, .bipolarRange, .internalClkMode,
        .fullPowerDown, .standbyMode);
    analog_input_model src (.clk_sys, .trackHold, .posChannel, .dacCode, .level,
        .compHigh);

    initial begin
        forever #10 clk_sys = ~clk_sys;
    end

    // ----------------------------------------
    // host access tasks
    // ----------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask : step

    task automatic wr(input logic [7:0] b);
        chipSelN = 1'b0;
        hostData = b;
        step(6);
        writeN = 1'b0;
        step(6);
        writeN = 1'b1;
        step(6);
        chipSelN = 1'b1;
        step(4);
    endtask : wr

    task automatic rd(input logic hb, output logic [7:0] v);
        high_byte_select = hb;
        chipSelN = 1'b0;
        step(2);
        readN = 1'b0;
        step(10);
        `CHK("bus enable", 1'b0, dataOeN)
        v = dataOut;
        readN = 1'b1;
        step(2);
        chipSelN = 1'b1;
        step(8);
        `CHK("bus release", 1'b1, dataOeN)
    endtask : rd

    // external clock toggles every 4 cycles: 6.25 MHz, 50% duty
    task automatic waitDone(input logic ext);
        n = 0;
        chipSelN = ~ext;
        while (convDoneN !== 1'b0 && n < 600) begin
            step(1);
            n++;
            if (ext && n % 4 == 0) convClkPin = ~convClkPin;
        end
        chipSelN = 1'b1;
        step(4);
        `CHK("done", 1'b0, convDoneN)
    endtask : waitDone

    task automatic conv(input logic [7:0] b, input logic ext, input logic [11:0] code);
        wr(b);
        waitDone(ext);
        rd(1'b0, rdLo);
        rd(1'b1, rdHi);
        `CHK("result", code, {rdHi[3:0], rdLo})
        `CHK("fill", {4{code[11] & ~b[3]}}, rdHi[7:4])
        `CHK("done cleared", 1'b1, convDoneN)
    endtask : conv

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 10000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        level = '{12'h123, 12'h456, 12'h789, 12'hA5C, 12'h0F0, 12'h123, 12'h800, 12'h7E1};
        step(16);
        reset_n = 1'b1;
        step(6);
        `CHK("clock mode", 1'b0, internalClkMode)
        `CHK("done", 1'b1, convDoneN)
        `CHK("bus", 1'b1, dataOeN)
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            wr(PWR_BYTE[i]);
            `CHK("power", PWR_EXP[i], {internalClkMode, fullPowerDown, standbyMode})
        end
        $display("test power done");
        for (int i = 0; i < 16; i++) begin
            wr({3'b100, i[3], 1'b1, i[2:0]});
            `CHK("pos", i[2:0], posChannel)
            `CHK("neg", i[3] ? 3'h0 : (i[2:0] ^ 3'h1), negChannel)
            `CHK("shared", i[3], negIsSharedReturn)
            `CHK("range", 1'b0, bipolarRange)
        end
        $display("test decode done");
        hostData = 8'h40;
        writeN = 1'b0;
        step(6);
        writeN = 1'b1;
        readN = 1'b0;
        step(10);
        `CHK("bus", 1'b1, dataOeN)
        readN = 1'b1;
        step(6);
        `CHK("range", 1'b0, bipolarRange)
        `CHK("power", 3'h4, {internalClkMode, fullPowerDown, standbyMode})
        $display("test deselect done");
        wr(8'hBB);
        step(300);
        `CHK("tracking", 1'b1, trackHold)
        `CHK("no result", 1'b1, convDoneN)
        conv(8'h9B, 1'b0, 12'hA5C);
        `CHK("host conv time", 1'b1, n inside {[145:180]})
        $display("test host acquisition done");
        conv(8'h9D, 1'b0, 12'h123);
        `CHK("conv time", 1'b1, n inside {[170:215]})
        conv(8'h95, 1'b0, 12'h923);
        $display("test timed done");
        wr(8'h9D);
        step(100);
        conv(8'h9F, 1'b0, 12'h7E1);
        `CHK("abort time", 1'b1, n inside {[170:215]})
        $display("test abort done");
        conv(8'hDB, 1'b1, 12'hA5C);
        `CHK("clock mode", 1'b0, internalClkMode)
        $display("test external clock done");
        tally_and_finish();
    end
endmodule : testbench
